// ### include/isf_pkg.sv
// Package for the interconnect security filter: modes, structs, constants
package isf_pkg;

	// Number of downstream APB ports
	localparam int unsigned ISF_APB_PORTS = 16;
	// Address and data widths used on the request carriers
	localparam int unsigned ISF_AW = 32;
	localparam int unsigned ISF_DW = 32;
	// Position of the security bit inside a three-bit protection field
	localparam int unsigned ISF_PROT_NS_BIT = 1;
	// Reset values of the programmable security bits
	localparam logic ISF_AHB_IN_CTRL_RST = 1'b1;
	localparam logic ISF_AHB_OUT_CTRL_RST = 1'b0;
	localparam logic [ISF_APB_PORTS-1:0] ISF_APB_CTRL_RST = 16'h0000;
	// Zero data returned by a blocked read
	localparam logic [ISF_DW-1:0] ISF_ZERO_DATA = 32'h00000000;

	// Security source of one interface
	typedef enum logic [1:0]
	{
		ISF_SEC_PIN = 2'h0,
		ISF_SEC_PROG = 2'h1,
		ISF_SEC_ALWAYS_S = 2'h2,
		ISF_SEC_ALWAYS_NS = 2'h3
	} isf_sec_mode_e;

	// Request carrier: one transfer offered to a filter
	typedef struct packed
	{
		logic valid;
		logic write;
		logic nonsec;
		logic [ISF_AW-1:0] addr;
		logic [ISF_DW-1:0] wdata;
	} isf_req_s;

	// Answer carrier: completion of one transfer
	typedef struct packed
	{
		logic done;
		logic err;
		logic [ISF_DW-1:0] rdata;
	} isf_rsp_s;

	// Access denied when a Non-secure request meets a secure target
	function automatic logic isf_denied(input logic req_nonsec, input logic tgt_secure);
		isf_denied = req_nonsec & tgt_secure;
	endfunction : isf_denied

endpackage : isf_pkg

// ### rtl/isf_apb_port.sv
// One APB egress port: security check, local termination, forwarding
module isf_apb_port
#(
	parameter isf_pkg::isf_sec_mode_e MODE = isf_pkg::ISF_SEC_PROG,
	parameter bit IS_APB4 = 1'b1,
	parameter bit ERR_ON_BLOCK = 1'b1
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Control bit for this port
	input wire logic ctrl_ns,
	// Request from the network and its answer
	input wire isf_pkg::isf_req_s req,
	output isf_pkg::isf_rsp_s rsp,
	// Downstream side
	output isf_pkg::isf_req_s fwd,
	output logic [2:0] pprot,
	input wire isf_pkg::isf_rsp_s fwd_rsp
);
	import isf_pkg::*;

	// Target secure decode per mode; pin mode lets the slave decide
	wire tgt_secure = (MODE == ISF_SEC_ALWAYS_S) ? 1'b1 :
		(MODE == ISF_SEC_PROG) ? ~ctrl_ns : 1'b0;
	// Block decision made locally by the port
	wire blocked = isf_denied(req.nonsec, tgt_secure);
	// Error flavour: SLVERR only where the protocol carries it
	wire use_err = ERR_ON_BLOCK && IS_APB4 &&
		(MODE != ISF_SEC_ALWAYS_NS);
	// Attribute on PPROT; APB3 ports drive none
	wire [2:0] next_pprot = IS_APB4 ? {1'b0, req.nonsec, 1'b0} : 3'h0;

	// Register the forward path and the local answer
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			fwd <= '0;
			pprot <= 3'h0;
			rsp <= '0;
		end
		else
		begin
			// Forward only permitted requests
			fwd <= req;
			fwd.valid <= req.valid & ~blocked;
			pprot <= next_pprot;
			// Blocked: zero read data, write dropped, local answer
			if (req.valid && blocked)
				rsp <= '{done: 1'b1, err: use_err, rdata: ISF_ZERO_DATA};
			else
				rsp <= fwd_rsp;
		end
	end

	// Blocked request never leaves the port
	property p_no_fwd_blocked;
		@(posedge clk) disable iff (!reset_n)
		(req.valid && blocked) |=> !fwd.valid;
	endproperty
	a_no_fwd_blocked: assert property (p_no_fwd_blocked)
		else $error("blocked APB request forwarded");

	// Blocked answer carries zero data and the chosen error flavour
	property p_block_rsp;
		@(posedge clk) disable iff (!reset_n)
		(req.valid && blocked) |=>
			(rsp.done && rsp.rdata == ISF_ZERO_DATA && rsp.err == $past(use_err));
	endproperty
	a_block_rsp: assert property (p_block_rsp) else $error("blocked APB answer wrong");

	// PPROT carries the attribute of a forwarded APB4 request
	property p_pprot;
		@(posedge clk) disable iff (!reset_n)
		(req.valid && !blocked && IS_APB4) |=>
			(fwd.valid && pprot[ISF_PROT_NS_BIT] == $past(req.nonsec));
	endproperty
	a_pprot: assert property (p_pprot) else $error("PPROT attribute wrong");

	// Cover a blocked and a passed request
	c_apb_block: cover property (@(posedge clk) disable iff (!reset_n) req.valid && blocked);
	c_apb_pass: cover property (@(posedge clk) disable iff (!reset_n) req.valid && !blocked);

endmodule : isf_apb_port

// ### rtl/isf_filter.sv
// Security filter: AXI pass-through, AHB ingress/egress, APB egress ports
module isf_filter
#(
	parameter bit AHB_IN_SECURE_XFERS = 1'b1,
	parameter isf_pkg::isf_sec_mode_e AHB_IN_MODE = isf_pkg::ISF_SEC_PROG,
	parameter bit AHB_OUT_SECURE_XFERS = 1'b1,
	parameter isf_pkg::isf_sec_mode_e AHB_OUT_MODE = isf_pkg::ISF_SEC_PROG,
	parameter logic [isf_pkg::ISF_APB_PORTS-1:0] APB_IS_APB4 = 16'hFFFF,
	parameter logic [2*isf_pkg::ISF_APB_PORTS-1:0] APB_MODE_PACK = 32'h55555555,
	parameter logic [isf_pkg::ISF_APB_PORTS-1:0] APB_ERR_ON_BLOCK = 16'hFFFF
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// AXI ingress protection in, AXI egress protection out
	input wire logic axi_in_valid,
	input wire logic [2:0] axi_in_prot,
	output logic axi_out_valid,
	output logic [2:0] axi_out_prot,
	// Control bits written by software (one-cycle write strobes)
	input wire logic ctrl_wr,
	input wire logic ahb_ingress_control_in,
	input wire logic ahb_egress_control_in,
	input wire logic [isf_pkg::ISF_APB_PORTS-1:0] apb_egress_control_in,
	// Control bits read back
	output logic ahb_ingress_control,
	output logic ahb_egress_control,
	output logic [isf_pkg::ISF_APB_PORTS-1:0] apb_egress_control,
	// AHB ingress: request attribute from upstream master
	input wire logic ahb_in_valid,
	input wire logic ahb_in_hnonsec,
	output logic ahb_in_marked_nonsec,
	// Internal register access from any source
	input wire isf_pkg::isf_req_s reg_req,
	input wire logic reg_secure_target,
	input wire logic [isf_pkg::ISF_DW-1:0] reg_rdata,
	output logic reg_wen,
	output isf_pkg::isf_rsp_s reg_rsp,
	// AHB egress towards downstream slave
	input wire isf_pkg::isf_req_s ahb_out_req,
	output isf_pkg::isf_rsp_s ahb_out_rsp,
	output isf_pkg::isf_req_s ahb_out_fwd,
	output logic ahb_out_hnonsec,
	input wire isf_pkg::isf_rsp_s ahb_out_slave_rsp,
	// APB egress ports
	input wire isf_pkg::isf_req_s [isf_pkg::ISF_APB_PORTS-1:0] apb_req,
	output isf_pkg::isf_rsp_s [isf_pkg::ISF_APB_PORTS-1:0] apb_rsp,
	output isf_pkg::isf_req_s [isf_pkg::ISF_APB_PORTS-1:0] apb_fwd,
	output logic [isf_pkg::ISF_APB_PORTS-1:0][2:0] apb_pprot,
	input wire isf_pkg::isf_rsp_s [isf_pkg::ISF_APB_PORTS-1:0] apb_slave_rsp
);
	import isf_pkg::*;

	// Pin inputs from upstream pass two flops before use
	logic hnonsec_meta;
	logic hnonsec_sync;

	// Ingress attribute: pin mode only where secure transfers exist
	wire in_pin_ns = AHB_IN_SECURE_XFERS ? hnonsec_sync : 1'b1;
	wire next_in_ns = (AHB_IN_MODE == ISF_SEC_PIN) ? in_pin_ns :
		(AHB_IN_MODE == ISF_SEC_PROG) ? ahb_ingress_control :
		(AHB_IN_MODE == ISF_SEC_ALWAYS_S) ? 1'b0 : 1'b1;

	// Egress target security; pin mode leaves the check to the slave
	wire out_tgt_secure = (AHB_OUT_MODE == ISF_SEC_ALWAYS_S) ? 1'b1 :
		(AHB_OUT_MODE == ISF_SEC_PROG) ? ~ahb_egress_control : 1'b0;
	wire out_blocked = isf_denied(ahb_out_req.nonsec, out_tgt_secure);
	// HNONSEC only exists with secure transfers; otherwise held low
	wire next_out_hnonsec = AHB_OUT_SECURE_XFERS & ahb_out_req.nonsec;

	// Register access gate for Non-secure requests
	wire reg_blocked = isf_denied(reg_req.nonsec, reg_secure_target);

	// Synchroniser for the ingress pin
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			hnonsec_meta <= 1'b0;
			hnonsec_sync <= 1'b0;
		end
		else
		begin
			hnonsec_meta <= ahb_in_hnonsec;
			hnonsec_sync <= hnonsec_meta;
		end
	end

	// Control bits: software writes, reset values set security defaults
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			ahb_ingress_control <= ISF_AHB_IN_CTRL_RST;
			ahb_egress_control <= ISF_AHB_OUT_CTRL_RST;
			apb_egress_control <= ISF_APB_CTRL_RST;
		end
		else if (ctrl_wr)
		begin
			ahb_ingress_control <= ahb_ingress_control_in;
			ahb_egress_control <= ahb_egress_control_in;
			apb_egress_control <= apb_egress_control_in;
		end
	end

	// AXI security bit carried unchanged
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			axi_out_valid <= 1'b0;
			axi_out_prot <= 3'h0;
		end
		else
		begin
			axi_out_valid <= axi_in_valid;
			axi_out_prot <= axi_in_prot;
		end
	end

	// AHB ingress marking
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			ahb_in_marked_nonsec <= ISF_AHB_IN_CTRL_RST;
		else if (ahb_in_valid)
			ahb_in_marked_nonsec <= next_in_ns;
	end

	// Internal registers: zeros and dropped writes, never an error
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			reg_wen <= 1'b0;
			reg_rsp <= '0;
		end
		else
		begin
			reg_wen <= reg_req.valid & reg_req.write & ~reg_blocked;
			reg_rsp.done <= reg_req.valid;
			reg_rsp.err <= 1'b0;
			reg_rsp.rdata <= reg_blocked ? ISF_ZERO_DATA : reg_rdata;
		end
	end

	// AHB egress: forward permitted transfers, answer blocked locally
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			ahb_out_fwd <= '0;
			ahb_out_hnonsec <= 1'b0;
			ahb_out_rsp <= '0;
		end
		else
		begin
			ahb_out_fwd <= ahb_out_req;
			ahb_out_fwd.valid <= ahb_out_req.valid & ~out_blocked;
			ahb_out_hnonsec <= next_out_hnonsec;
			// Blocked: zero data, no error; else slave answer
			if (ahb_out_req.valid && out_blocked)
				ahb_out_rsp <= '{done: 1'b1, err: 1'b0, rdata: ISF_ZERO_DATA};
			else
				ahb_out_rsp <= ahb_out_slave_rsp;
		end
	end

	// One filter per APB port, each with its own build options
	for (genvar i = 0; i < ISF_APB_PORTS; i++)
	begin : g_apb
		isf_apb_port #(
			.MODE(isf_sec_mode_e'(APB_MODE_PACK[2*i +: 2])),
			.IS_APB4(APB_IS_APB4[i]),
			.ERR_ON_BLOCK(APB_ERR_ON_BLOCK[i])
		) u_port (
			.clk(clk),
			.reset_n(reset_n),
			.ctrl_ns(apb_egress_control[i]),
			.req(apb_req[i]),
			.rsp(apb_rsp[i]),
			.fwd(apb_fwd[i]),
			.pprot(apb_pprot[i]),
			.fwd_rsp(apb_slave_rsp[i])
		);
	end

	// AXI security bit one cycle later, unchanged
	property p_axi_prot;
		@(posedge clk) disable iff (!reset_n)
		axi_in_valid |=> (axi_out_valid &&
			axi_out_prot[ISF_PROT_NS_BIT] == $past(axi_in_prot[ISF_PROT_NS_BIT]));
	endproperty
	a_axi_prot: assert property (p_axi_prot) else $error("AXI security bit altered");

	// Blocked register read returns zero without error
	property p_reg_block;
		@(posedge clk) disable iff (!reset_n)
		(reg_req.valid && reg_blocked) |=>
			(!reg_wen && reg_rsp.done && !reg_rsp.err && reg_rsp.rdata == ISF_ZERO_DATA);
	endproperty
	a_reg_block: assert property (p_reg_block) else $error("secure register reached");

	// Non-secure ingress marked when programmed
	property p_in_mark;
		@(posedge clk) disable iff (!reset_n)
		(ahb_in_valid && AHB_IN_MODE == ISF_SEC_PROG) |=> ahb_in_marked_nonsec == $past(ahb_ingress_control);
	endproperty
	a_in_mark: assert property (p_in_mark) else $error("ingress marking wrong");

	// Blocked AHB egress transfer not forwarded, answered clean
	property p_out_block;
		@(posedge clk) disable iff (!reset_n)
		(ahb_out_req.valid && out_blocked) |=> (!ahb_out_fwd.valid && ahb_out_rsp.done &&
			!ahb_out_rsp.err && ahb_out_rsp.rdata == ISF_ZERO_DATA);
	endproperty
	a_out_block: assert property (p_out_block) else $error("AHB egress block wrong");

	// HNONSEC follows the forwarded transfer's attribute
	property p_hnonsec;
		@(posedge clk) disable iff (!reset_n)
		(ahb_out_req.valid && !out_blocked && AHB_OUT_SECURE_XFERS) |=>
			ahb_out_hnonsec == $past(ahb_out_req.nonsec);
	endproperty
	a_hnonsec: assert property (p_hnonsec) else $error("HNONSEC level wrong");

	// Reset values of the control bits
	property p_ctrl_reset;
		@(posedge clk)
		!reset_n |=> (ahb_ingress_control && !ahb_egress_control && apb_egress_control == ISF_APB_CTRL_RST);
	endproperty
	a_ctrl_reset: assert property (p_ctrl_reset) else $error("control reset wrong");

	// Idle AXI input gives an idle AXI output
	property p_axi_idle;
		@(posedge clk) disable iff (!reset_n)
		!axi_in_valid |=> !axi_out_valid;
	endproperty
	a_axi_idle: assert property (p_axi_idle) else $error("AXI output not idle");

	// Permitted register access reaches the register file
	property p_reg_pass;
		@(posedge clk) disable iff (!reset_n)
		(reg_req.valid && !reg_blocked) |=> (reg_wen == $past(reg_req.write) &&
			reg_rsp.done && reg_rsp.rdata == $past(reg_rdata));
	endproperty
	a_reg_pass: assert property (p_reg_pass) else $error("register access lost");

	// Control bits load from the write data on a strobe
	property p_ctrl_load;
		@(posedge clk) disable iff (!reset_n)
		ctrl_wr |=> (ahb_ingress_control == $past(ahb_ingress_control_in) &&
			ahb_egress_control == $past(ahb_egress_control_in) &&
			apb_egress_control == $past(apb_egress_control_in));
	endproperty
	a_ctrl_load: assert property (p_ctrl_load) else $error("control bits not loaded");

	// Pin mode marks ingress from the synchronised attribute
	property p_in_pin;
		@(posedge clk) disable iff (!reset_n)
		(ahb_in_valid && AHB_IN_MODE == ISF_SEC_PIN && AHB_IN_SECURE_XFERS) |=>
			ahb_in_marked_nonsec == $past(hnonsec_sync);
	endproperty
	a_in_pin: assert property (p_in_pin) else $error("pin marking wrong");

	// Always-secure egress never forwards a Non-secure transfer
	property p_out_always_s;
		@(posedge clk) disable iff (!reset_n)
		(ahb_out_req.valid && ahb_out_req.nonsec && AHB_OUT_MODE == ISF_SEC_ALWAYS_S) |=>
			!ahb_out_fwd.valid;
	endproperty
	a_out_always_s: assert property (p_out_always_s) else $error("secure egress leaked");

	// Permitted AHB egress transfer forwarded with its address
	property p_out_pass;
		@(posedge clk) disable iff (!reset_n)
		(ahb_out_req.valid && !out_blocked) |=>
			(ahb_out_fwd.valid && ahb_out_fwd.addr == $past(ahb_out_req.addr));
	endproperty
	a_out_pass: assert property (p_out_pass) else $error("AHB egress transfer lost");

	// Slave answer passes through whenever nothing is blocked
	property p_out_slave;
		@(posedge clk) disable iff (!reset_n)
		!(ahb_out_req.valid && out_blocked) |=> ahb_out_rsp == $past(ahb_out_slave_rsp);
	endproperty
	a_out_slave: assert property (p_out_slave) else $error("AHB slave answer lost");

	// Main scenarios
	c_reg_block: cover property (@(posedge clk) disable iff (!reset_n) reg_req.valid && reg_blocked);
	c_out_block: cover property (@(posedge clk) disable iff (!reset_n) ahb_out_req.valid && out_blocked);
	c_ctrl_wr: cover property (@(posedge clk) disable iff (!reset_n) ctrl_wr ##1 ahb_out_req.valid);

endmodule : isf_filter

// ### bench/isf_slave_model.sv
// Downstream slave model answering forwarded transfers one cycle later
module isf_slave_model
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Forwarded request and the slave's answer
	input wire isf_pkg::isf_req_s fwd,
	output isf_pkg::isf_rsp_s rsp
);
	timeunit 1ns;
	timeprecision 1ps;
	import isf_pkg::*;

	// Answer data is the inverted address; idle data keeps toggling, so a stale
	// answer value comes back on every second idle cycle
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			rsp <= '0;
		else
		begin
			rsp.done <= fwd.valid;
			rsp.err <= 1'b0;
			rsp.rdata <= fwd.valid ? ~fwd.addr : ~rsp.rdata;
		end
	end
endmodule : isf_slave_model

// ### bench/isf_filter_tb_top.sv
// Self-checking testbench for the interconnect security filter
module isf_filter_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import isf_pkg::*;

	// Port 0 prog, 1 always S, 2 always NS, 3 pin, 4 prog on APB3
	localparam logic [15:0] APB4 = 16'hFFEF;
	localparam logic [31:0] ADDR = 32'h00000040;
	logic clk, reset_n, axi_in_valid, axi_out_valid, ctrl_wr;
	logic ahb_ingress_control_in, ahb_egress_control_in;
	logic ahb_ingress_control, ahb_egress_control;
	logic ahb_in_valid, ahb_in_hnonsec, ahb_in_marked_nonsec;
	logic reg_secure_target, reg_wen, ahb_out_hnonsec, fx_marked;
	logic [2:0] axi_in_prot, axi_out_prot;
	logic [15:0] apb_egress_control_in, apb_egress_control;
	logic [31:0] reg_rdata;
	isf_req_s reg_req, ahb_out_req, ahb_out_fwd, fx_fwd;
	isf_rsp_s reg_rsp, ahb_out_rsp, ahb_out_slave_rsp, fx_rsp;
	isf_req_s [15:0] apb_req, apb_fwd;
	isf_rsp_s [15:0] apb_rsp, apb_slave_rsp;
	logic [15:0][2:0] apb_pprot;
	int n_fail = 0;
	int n_tests = 0;

	isf_filter #(.APB_IS_APB4(APB4), .APB_MODE_PACK(32'h55555539)) isf_filter_i (
		.clk(clk), .reset_n(reset_n), .axi_in_valid(axi_in_valid),
		.axi_in_prot(axi_in_prot), .axi_out_valid(axi_out_valid),
		.axi_out_prot(axi_out_prot), .ctrl_wr(ctrl_wr),
		.ahb_ingress_control_in(ahb_ingress_control_in),
		.ahb_egress_control_in(ahb_egress_control_in),
		.apb_egress_control_in(apb_egress_control_in),
		.ahb_ingress_control(ahb_ingress_control),
		.ahb_egress_control(ahb_egress_control),
		.apb_egress_control(apb_egress_control), .ahb_in_valid(ahb_in_valid),
		.ahb_in_hnonsec(ahb_in_hnonsec), .ahb_in_marked_nonsec(ahb_in_marked_nonsec),
		.reg_req(reg_req), .reg_secure_target(reg_secure_target),
		.reg_rdata(reg_rdata), .reg_wen(reg_wen), .reg_rsp(reg_rsp),
		.ahb_out_req(ahb_out_req), .ahb_out_rsp(ahb_out_rsp),
		.ahb_out_fwd(ahb_out_fwd), .ahb_out_hnonsec(ahb_out_hnonsec),
		.ahb_out_slave_rsp(ahb_out_slave_rsp), .apb_req(apb_req),
		.apb_rsp(apb_rsp), .apb_fwd(apb_fwd), .apb_pprot(apb_pprot),
		.apb_slave_rsp(apb_slave_rsp));

	// One slave model on the AHB side and one per APB port
	isf_slave_model isf_slave_model_i (.clk(clk), .reset_n(reset_n),
		.fwd(ahb_out_fwd), .rsp(ahb_out_slave_rsp));
	for (genvar g = 0; g < 16; g++)
	begin : g_apb
		isf_slave_model isf_slave_model_i (.clk(clk), .reset_n(reset_n),
			.fwd(apb_fwd[g]), .rsp(apb_slave_rsp[g]));
	end

	// Second build: pin-marked ingress, always-secure egress
	if (1)
	begin : g_fixed
		isf_filter #(.AHB_IN_MODE(ISF_SEC_PIN), .AHB_OUT_MODE(ISF_SEC_ALWAYS_S)) isf_filter_i (
			.clk(clk), .reset_n(reset_n), .axi_in_valid(axi_in_valid),
			.axi_in_prot(axi_in_prot), .axi_out_valid(), .axi_out_prot(),
			.ctrl_wr(ctrl_wr), .ahb_ingress_control_in(ahb_ingress_control_in),
			.ahb_egress_control_in(ahb_egress_control_in),
			.apb_egress_control_in(apb_egress_control_in), .ahb_ingress_control(),
			.ahb_egress_control(), .apb_egress_control(), .ahb_in_valid(ahb_in_valid),
			.ahb_in_hnonsec(ahb_in_hnonsec), .ahb_in_marked_nonsec(fx_marked),
			.reg_req(reg_req), .reg_secure_target(reg_secure_target),
			.reg_rdata(reg_rdata), .reg_wen(), .reg_rsp(), .ahb_out_req(ahb_out_req),
			.ahb_out_rsp(fx_rsp), .ahb_out_fwd(fx_fwd), .ahb_out_hnonsec(),
			.ahb_out_slave_rsp(ahb_out_slave_rsp), .apb_req(apb_req), .apb_rsp(),
			.apb_fwd(), .apb_pprot(), .apb_slave_rsp(apb_slave_rsp));
	end

	// Free-running clock, 4 ns period
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Single comparison point
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Verdict and end of run
	task automatic print_verdict();
		if (n_fail == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict

	// Control write: one strobe, then read back
	task automatic set_ctrl(input logic i, input logic o, input logic [15:0] a);
		@(negedge clk);
		{ahb_ingress_control_in, ahb_egress_control_in} = {i, o};
		apb_egress_control_in = a;
		ctrl_wr = 1'b1;
		@(negedge clk);
		ctrl_wr = 1'b0;
		chk({ahb_ingress_control, ahb_egress_control}, {i, o});
		chk(apb_egress_control, a);
	endtask : set_ctrl

	// Protection bits go through unchanged, back to back
	task automatic axi_test();
		logic [2:0] v [4] = '{3'h2, 3'h5, 3'h7, 3'h0};
		@(negedge clk);
		axi_in_valid = 1'b1;
		axi_in_prot = v[0];
		for (int k = 1; k <= 4; k++)
		begin
			@(negedge clk);
			chk({axi_out_valid, axi_out_prot}, {1'b1, v[k-1]});
			if (k < 4)
				axi_in_prot = v[k];
		end
		axi_in_valid = 1'b0;
	endtask : axi_test

	// Register access against a secure register
	task automatic reg_acc(input logic w, input logic ns, input logic wen, input logic [31:0] rd);
		@(negedge clk);
		reg_req = '{1'b1, w, ns, ADDR, 32'h12345678};
		reg_secure_target = 1'b1;
		@(negedge clk);
		reg_req = '0;
		chk({reg_wen, reg_rsp.done, reg_rsp.err}, {wen, 2'h2});
		if (!w)
			chk(reg_rsp.rdata, rd);
	endtask : reg_acc

	// Ingress marking follows the control bit
	task automatic ingress_test(input logic b);
		set_ctrl(b, 1'b0, 16'h0000);
		@(negedge clk);
		ahb_in_valid = 1'b1;
		@(negedge clk);
		ahb_in_valid = 1'b0;
		chk(ahb_in_marked_nonsec, b);
	endtask : ingress_test

	// One transfer on an APB port, or on the AHB egress when p is 16
	task automatic xfer(input int p, input logic ns, input logic w, input logic blk,
		input logic err);
		isf_req_s f;
		isf_rsp_s s;
		logic pp;
		@(negedge clk);
		if (p == 16)
			ahb_out_req = '{1'b1, w, ns, ADDR, 32'hCAFE0001};
		else
			apb_req[p] = '{1'b1, w, ns, ADDR, 32'hCAFE0001};
		@(negedge clk);
		f = (p == 16) ? ahb_out_fwd : apb_fwd[p];
		s = (p == 16) ? ahb_out_rsp : apb_rsp[p];
		pp = (p == 16) ? ahb_out_hnonsec : apb_pprot[p][1];
		ahb_out_req = '0;
		apb_req = '0;
		chk(f.valid, !blk);
		if (blk)
		begin
			chk({s.done, s.err}, {1'b1, err});
			chk(s.rdata, ISF_ZERO_DATA);
		end
		else
		begin
			chk(pp, ns & (p == 16 || APB4[p]));
			repeat (2) @(negedge clk);
			s = (p == 16) ? ahb_out_rsp : apb_rsp[p];
			chk(s.rdata, ~ADDR);
		end
	endtask : xfer

	// Second build: pin attribute marks ingress, secure egress refuses Non-secure
	task automatic fixed_test(input logic b);
		@(negedge clk);
		ahb_in_hnonsec = b;
		repeat (2) @(negedge clk);
		ahb_in_valid = 1'b1;
		ahb_out_req = '{1'b1, 1'b0, b, ADDR, 32'hCAFE0002};
		@(negedge clk);
		ahb_in_valid = 1'b0;
		ahb_out_req = '0;
		chk(fx_marked, b);
		chk(fx_fwd.valid, !b);
		if (b)
		begin
			chk({fx_rsp.done, fx_rsp.err}, 2'h2);
			chk(fx_rsp.rdata, ISF_ZERO_DATA);
		end
	endtask : fixed_test

	// Watchdog cuts a hang short
	initial
	begin
		#20000;
		n_fail++;
		print_verdict();
	end

	// Main sequence
	initial
	begin
		{reset_n, axi_in_valid, ctrl_wr, ahb_in_valid, ahb_in_hnonsec} = '0;
		{ahb_ingress_control_in, ahb_egress_control_in, reg_secure_target} = '0;
		{axi_in_prot, apb_egress_control_in} = '0;
		{reg_req, ahb_out_req, apb_req} = '0;
		reg_rdata = 32'hA5A50F0F;
		repeat (6) @(negedge clk);
		reset_n = 1'b1;
		chk({ahb_ingress_control, ahb_egress_control, ahb_in_marked_nonsec}, 3'h5);
		chk(apb_egress_control, ISF_APB_CTRL_RST);
		axi_test();
		reg_acc(1'b1, 1'b1, 1'b0, 32'h0);
		reg_acc(1'b0, 1'b1, 1'b0, ISF_ZERO_DATA);
		reg_acc(1'b1, 1'b0, 1'b1, 32'h0);
		reg_acc(1'b0, 1'b0, 1'b0, 32'hA5A50F0F);
		ingress_test(1'b1);
		ingress_test(1'b0);
		fixed_test(1'b1);
		fixed_test(1'b0);
		xfer(16, 1'b1, 1'b0, 1'b1, 1'b0);
		xfer(16, 1'b1, 1'b1, 1'b1, 1'b0);
		xfer(16, 1'b0, 1'b1, 1'b0, 1'b0);
		set_ctrl(1'b0, 1'b1, 16'h0000);
		xfer(16, 1'b1, 1'b0, 1'b0, 1'b0);
		xfer(0, 1'b1, 1'b0, 1'b1, 1'b1);
		xfer(0, 1'b0, 1'b0, 1'b0, 1'b0);
		xfer(1, 1'b1, 1'b1, 1'b1, 1'b1);
		xfer(2, 1'b1, 1'b0, 1'b0, 1'b0);
		xfer(3, 1'b1, 1'b0, 1'b0, 1'b0);
		xfer(4, 1'b1, 1'b1, 1'b1, 1'b0);
		set_ctrl(1'b0, 1'b1, 16'h0001);
		xfer(0, 1'b1, 1'b0, 1'b0, 1'b0);
		xfer(15, 1'b1, 1'b0, 1'b1, 1'b1);
		print_verdict();
	end
endmodule : isf_filter_tb_top
